// ### rtl/dmw_device.sv
// converter write port: register file, direction and decay outputs
//
// Operation
// - capture data on write strobe rising edge
// - eight-bit parallel write-only data port
// - two channels, seven-bit magnitude plus direction
// - channel 1 direction follows top data bit
// - channel 2 direction follows top data bit
// - decay output generated automatically, low is fast
// - channel select: low ch1, high ch2
// - kind select: low magnitude, high level
// - transfer only while chip select low
// - reset pin high clears registers
// - fast decay when new below old and level
// - level is data bits six to four
// - reset clears all flops to low, except the strobe history, which goes high
`include "dmw_defines.svh"

module dmw_device (
  input wire logic clk_i,
  input wire logic rst_i,
  dmw_link_if.dev link,
  output dmw_pkg::dmw_code_t analog_out_ch1_o,
  output dmw_pkg::dmw_code_t analog_out_ch2_o,
  output logic phase_dir_out_ch1_o,
  output logic phase_dir_out_ch2_o,
  output logic fast_decay_n_ch1_o,
  output logic fast_decay_n_ch2_o
);
  import dmw_pkg::*;

  // true when a new code asks for fast decay
  function automatic logic dmw_fast_req(
    input dmw_code_t new_code,
    input dmw_code_t old_code,
    input dmw_level_t level
  );
    logic below_old;
    logic below_level;
    below_old = new_code < old_code;
    below_level = new_code[`DMW_LVL_HI:`DMW_LVL_LO] < level;
    return below_old && below_level;
  endfunction : dmw_fast_req

  // write decode for one register slot
  function automatic logic dmw_hit(
    input logic take,
    input logic chan,
    input logic kind,
    input logic want_chan,
    input logic want_kind
  );
    return take && (chan == want_chan) && (kind == want_kind);
  endfunction : dmw_hit

  // reset from the local bus or from the device pin
  logic reset_all;
  // previous strobe level, for the edge
  logic wr_n_q;
  // strobe rising edge seen this cycle
  logic wr_rise;
  // rising edge with the chip selected
  logic take_write;
  // one strobe per register slot
  logic hit_mag1;
  logic hit_mag2;
  logic hit_lvl1;
  logic hit_lvl2;
  // new magnitude and level taken from the byte
  dmw_code_t new_code;
  dmw_level_t new_level;
  // stored magnitudes, levels, directions, decay flags
  dmw_code_t mag1_q;
  dmw_code_t mag2_q;
  dmw_level_t lvl1_q;
  dmw_level_t lvl2_q;
  logic dir1_q;
  logic dir2_q;
  logic decay_n1_q;
  logic decay_n2_q;

  // pin reset is synchronous too; the pin is kept low by the host when unused
  assign reset_all = rst_i | link.dev_rst;

  // strobe history; idles high so no edge is invented after reset
  always_ff @(posedge clk_i)
  begin
    if (reset_all)
    begin
      wr_n_q <= 1'b1;
    end
    else
    begin
      wr_n_q <= link.wr_n;
    end
  end

  // rising edge of the write strobe
  assign wr_rise = ~wr_n_q & link.wr_n;
  // a deselected edge is simply dropped
  assign take_write = wr_rise & ~link.cs_n;

  // four slots decoded from channel and kind selects
  assign hit_mag1 = dmw_hit(take_write, link.chan_sel, link.kind_sel, 1'b0, 1'b0);
  assign hit_lvl1 = dmw_hit(take_write, link.chan_sel, link.kind_sel, 1'b0, 1'b1);
  assign hit_mag2 = dmw_hit(take_write, link.chan_sel, link.kind_sel, 1'b1, 1'b0);
  assign hit_lvl2 = dmw_hit(take_write, link.chan_sel, link.kind_sel, 1'b1, 1'b1);

  // fields of the byte taken in parallel
  assign new_code = link.data[`DMW_MAG_HI:`DMW_MAG_LO];
  assign new_level = link.data[`DMW_LVL_HI:`DMW_LVL_LO];

  // channel 1 magnitude
  always_ff @(posedge clk_i)
  begin
    if (reset_all)
    begin
      mag1_q <= `DMW_MAG_RST;
    end
    else if (hit_mag1)
    begin
      mag1_q <= new_code;
    end
  end

  // channel 2 magnitude
  always_ff @(posedge clk_i)
  begin
    if (reset_all)
    begin
      mag2_q <= `DMW_MAG_RST;
    end
    else if (hit_mag2)
    begin
      mag2_q <= new_code;
    end
  end

  // decay thresholds; writing one never touches a decay output
  always_ff @(posedge clk_i)
  begin
    if (reset_all)
    begin
      lvl1_q <= `DMW_LVL_RST;
      lvl2_q <= `DMW_LVL_RST;
    end
    else
    begin
      if (hit_lvl1)
      begin
        lvl1_q <= new_level;
      end
      if (hit_lvl2)
      begin
        lvl2_q <= new_level;
      end
    end
  end

  // direction bits ride along with the magnitude write
  always_ff @(posedge clk_i)
  begin
    if (reset_all)
    begin
      dir1_q <= 1'b0;
      dir2_q <= 1'b0;
    end
    else
    begin
      if (hit_mag1)
      begin
        dir1_q <= link.data[`DMW_TOP_BIT];
      end
      if (hit_mag2)
      begin
        dir2_q <= link.data[`DMW_TOP_BIT];
      end
    end
  end

  // decay flags compare against the value held before this write,
  // so the old code is read here in the same edge it is replaced
  always_ff @(posedge clk_i)
  begin
    if (reset_all)
    begin
      // low after reset: all digital outputs start at ground
      decay_n1_q <= 1'b0;
      decay_n2_q <= 1'b0;
    end
    else
    begin
      if (hit_mag1)
      begin
        decay_n1_q <= ~dmw_fast_req(new_code, mag1_q, lvl1_q);
      end
      if (hit_mag2)
      begin
        decay_n2_q <= ~dmw_fast_req(new_code, mag2_q, lvl2_q);
      end
    end
  end

  // every output straight from a flop
  assign analog_out_ch1_o = mag1_q;
  assign analog_out_ch2_o = mag2_q;
  assign phase_dir_out_ch1_o = dir1_q;
  assign phase_dir_out_ch2_o = dir2_q;
  assign fast_decay_n_ch1_o = decay_n1_q;
  assign fast_decay_n_ch2_o = decay_n2_q;

endmodule : dmw_device

// ### rtl/dmw_defines.svh
// constants for the dual microstep converter write port
`ifndef DMW_DEFINES_SVH
`define DMW_DEFINES_SVH

// clock period in ns (40 MHz)
`define DMW_CLK_NS 25
// host strobe timing, ns
`define DMW_SETUP_NS 50
`define DMW_LOW_NS 100
`define DMW_HOLD_NS 25
// derived cycle counts, least times rounded up
`define DMW_SETUP_CYC (4'((`DMW_SETUP_NS + `DMW_CLK_NS - 1) / `DMW_CLK_NS))
`define DMW_LOW_CYC (4'((`DMW_LOW_NS + `DMW_CLK_NS - 1) / `DMW_CLK_NS))
`define DMW_HOLD_CYC (4'((`DMW_HOLD_NS + `DMW_CLK_NS - 1) / `DMW_CLK_NS))
// counter reset and step
`define DMW_CNT_ZERO 4'h0
`define DMW_CNT_ONE 4'h1

// data word layout
`define DMW_TOP_BIT 7
`define DMW_MAG_HI 6
`define DMW_MAG_LO 0
`define DMW_LVL_HI 6
`define DMW_LVL_LO 4
// reset values
`define DMW_MAG_RST 7'h00
`define DMW_LVL_RST 3'h0
`define DMW_BYTE_RST 8'h00

// host register byte offsets
`define DMW_REG_CMD 4'h0
`define DMW_REG_STATUS 4'h4
`define DMW_REG_RESET 4'h8
// command register fields
`define DMW_CMD_CHAN 8
`define DMW_CMD_KIND 9
`define DMW_CMD_BYTE_HI 7
`define DMW_CMD_BYTE_LO 0
// byte lanes and reset register bit
`define DMW_LANE_BYTE 0
`define DMW_LANE_SEL 1
`define DMW_RST_BIT 0
// status register fields
`define DMW_STAT_BUSY 0
// unmapped read value
`define DMW_RD_ZERO 32'h0000_0000

`endif

// ### rtl/dmw_pkg.sv
// types shared by both ends of the converter write port
package dmw_pkg;

  // seven-bit magnitude code
  typedef logic [6:0] dmw_code_t;
  // three-bit decay threshold
  typedef logic [2:0] dmw_level_t;

  // host strobe sequencer, one-hot
  typedef enum logic [3:0] {
    DMW_IDLE = 4'h1,
    DMW_SETUP = 4'h2,
    DMW_LOW = 4'h4,
    DMW_HOLD = 4'h8
  } dmw_state_t;

endpackage : dmw_pkg

// ### rtl/dmw_link_if.sv
// pin bundle between host bus master and converter write port
interface dmw_link_if;
  logic [7:0] data;  // write-only data byte
  logic chan_sel;  // low channel 1, high channel 2
  logic kind_sel;  // low magnitude, high decay level
  logic cs_n;  // chip select, active low
  logic wr_n;  // write strobe, data taken on rising edge
  logic dev_rst;  // device reset pin, active high

  // host drives every pin
  modport host (
    output data,
    output chan_sel,
    output kind_sel,
    output cs_n,
    output wr_n,
    output dev_rst
  );

  // device only listens
  modport dev (
    input data,
    input chan_sel,
    input kind_sel,
    input cs_n,
    input wr_n,
    input dev_rst
  );
endinterface : dmw_link_if

// ### rtl/dmw_host.sv
// host end: wishbone slave registers driving the converter write pins
`include "dmw_defines.svh"

module dmw_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  dmw_link_if.host link
);
  import dmw_pkg::*;

  // sequencer state and phase counter
  dmw_state_t state_q;
  logic [3:0] cnt_q;
  // latched command fields
  logic [7:0] byte_q;
  logic chan_q;
  logic kind_q;
  logic dev_rst_q;
  // bus handshake
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic wr_cmd;
  logic busy;
  logic phase_done;

  assign req = wb_cyc_i & wb_stb_i;
  // write lands at the edge where ack is seen high
  assign wr_cmd = req & ack_q & wb_we_i;
  assign busy = (state_q != DMW_IDLE);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
    end
  end

  // read mux; unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdat_q <= `DMW_RD_ZERO;
    end
    else if (req & ~ack_q)
    begin
      case (wb_adr_i)
        `DMW_REG_CMD: rdat_q <= {22'h0, kind_q, chan_q, byte_q};
        `DMW_REG_STATUS: rdat_q <= {31'h0, busy};
        `DMW_REG_RESET: rdat_q <= {31'h0, dev_rst_q};
        default: rdat_q <= `DMW_RD_ZERO;
      endcase
    end
  end

  // command latch; refused while a transfer runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      byte_q <= `DMW_BYTE_RST;
      chan_q <= 1'b0;
      kind_q <= 1'b0;
    end
    else if (wr_cmd && wb_adr_i == `DMW_REG_CMD && !busy)
    begin
      if (wb_sel_i[`DMW_LANE_BYTE])
      begin
        byte_q <= wb_dat_i[`DMW_CMD_BYTE_HI:`DMW_CMD_BYTE_LO];
      end
      if (wb_sel_i[`DMW_LANE_SEL])
      begin
        chan_q <= wb_dat_i[`DMW_CMD_CHAN];
        kind_q <= wb_dat_i[`DMW_CMD_KIND];
      end
    end
  end

  // device reset pin, low unless software raises it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dev_rst_q <= 1'b0;
    end
    else if (wr_cmd && wb_adr_i == `DMW_REG_RESET && wb_sel_i[`DMW_LANE_BYTE])
    begin
      dev_rst_q <= wb_dat_i[`DMW_RST_BIT];
    end
  end

  assign phase_done = (cnt_q == `DMW_CNT_ONE);

  // strobe sequencer: select, strobe low, rise, hold
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= DMW_IDLE;
      cnt_q <= `DMW_CNT_ZERO;
    end
    else
    begin
      case (state_q)
        DMW_IDLE:
        begin
          if (wr_cmd && wb_adr_i == `DMW_REG_CMD && wb_sel_i[`DMW_LANE_BYTE])
          begin
            state_q <= DMW_SETUP;
            cnt_q <= `DMW_SETUP_CYC;
          end
        end
        DMW_SETUP:
        begin
          cnt_q <= cnt_q - `DMW_CNT_ONE;
          if (phase_done)
          begin
            state_q <= DMW_LOW;
            cnt_q <= `DMW_LOW_CYC;
          end
        end
        DMW_LOW:
        begin
          cnt_q <= cnt_q - `DMW_CNT_ONE;
          if (phase_done)
          begin
            state_q <= DMW_HOLD;
            cnt_q <= `DMW_HOLD_CYC;
          end
        end
        DMW_HOLD:
        begin
          cnt_q <= cnt_q - `DMW_CNT_ONE;
          if (phase_done)
          begin
            state_q <= DMW_IDLE;
          end
        end
        default:
        begin
          state_q <= DMW_IDLE;
          cnt_q <= `DMW_CNT_ZERO;
        end
      endcase
    end
  end

  // pins: select and data stay stable across the rising strobe
  assign link.cs_n = ~busy;
  assign link.wr_n = (state_q != DMW_LOW);
  assign link.data = byte_q;
  assign link.chan_sel = chan_q;
  assign link.kind_sel = kind_q;
  assign link.dev_rst = dev_rst_q;
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

endmodule : dmw_host

// ### verification/dmw_link_monitor.sv
// checker for the converter write link and the device outputs
module dmw_link_monitor
  import dmw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] data,
  input wire logic chan_sel,
  input wire logic kind_sel,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic dev_rst,
  input wire dmw_code_t analog_out_ch1_o,
  input wire dmw_code_t analog_out_ch2_o,
  input wire logic phase_dir_out_ch1_o,
  input wire logic phase_dir_out_ch2_o,
  input wire logic fast_decay_n_ch1_o,
  input wire logic fast_decay_n_ch2_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic wr_q; // strobe level one cycle ago
  dmw_level_t lvl1_q; // shadow of channel 1 threshold
  dmw_level_t lvl2_q; // shadow of channel 2 threshold
  logic tk; // a selected strobe rise
  logic [17:0] outs; // all device outputs together
  assign tk = !cs_n && wr_n && !wr_q;
  assign outs = {analog_out_ch1_o, analog_out_ch2_o, phase_dir_out_ch1_o,
    phase_dir_out_ch2_o, fast_decay_n_ch1_o, fast_decay_n_ch2_o};
  // remember the strobe to find its rising edge
  always_ff @(posedge clk_i)
  begin
    wr_q <= rst_i ? 1'b1 : wr_n;
  end
  // shadow thresholds, cleared like the device registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i || dev_rst)
    begin
      lvl1_q <= 3'h0;
      lvl2_q <= 3'h0;
    end
    else if (tk && kind_sel && !chan_sel)
      lvl1_q <= data[6:4];
    else if (tk && kind_sel && chan_sel)
      lvl2_q <= data[6:4];
  end
  // host strobe shape after selecting the device
  sequence s_setup;
    wr_n ##1 wr_n;
  endsequence
  sequence s_pulse;
    (!wr_n) [*4] ##1 (wr_n && !cs_n) ##1 cs_n;
  endsequence
  a_strobe_frame: assert property ($fell(cs_n) |-> s_setup ##1 s_pulse)
    else $error("strobe frame shape wrong");
  a_data_steady: assert property (
    !cs_n && !$past(cs_n) |-> $stable({data, chan_sel, kind_sel}))
    else $error("data moved while selected");
  a_dir_one: assert property (tk && !kind_sel && !chan_sel |=>
    phase_dir_out_ch1_o == $past(data[7]) && analog_out_ch1_o == $past(data[6:0]))
    else $error("channel 1 direction or magnitude wrong");
  a_dir_two: assert property (tk && !kind_sel && chan_sel |=>
    phase_dir_out_ch2_o == $past(data[7]) && analog_out_ch2_o == $past(data[6:0]))
    else $error("channel 2 direction or magnitude wrong");
  a_decay_one: assert property (tk && !kind_sel && !chan_sel |=> fast_decay_n_ch1_o ==
    !(($past(data[6:0]) < $past(analog_out_ch1_o)) && ($past(data[6:4]) < $past(lvl1_q))))
    else $error("channel 1 decay wrong");
  a_decay_two: assert property (tk && !kind_sel && chan_sel |=> fast_decay_n_ch2_o ==
    !(($past(data[6:0]) < $past(analog_out_ch2_o)) && ($past(data[6:4]) < $past(lvl2_q))))
    else $error("channel 2 decay wrong");
  a_level_quiet: assert property (tk && kind_sel |=> $stable(outs))
    else $error("level write moved an output");
  a_hold_still: assert property (!tk && !dev_rst |=> $stable(outs))
    else $error("outputs moved without a write");
  a_pin_clear: assert property (dev_rst |=> outs == 18'h00000)
    else $error("reset pin left outputs set");
endmodule : dmw_link_monitor

// ### verification/dmw_tb_top.sv
// testbench: wishbone host driving the converter write port
module dmw_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmw_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] adr = 4'h0; // wishbone request lines
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic [31:0] rdat;
  logic ack;
  dmw_code_t a1, a2;
  logic d1, d2, f1, f2;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [6:0] mag [2]; // expected magnitudes
  logic [2:0] lvl [2]; // expected thresholds
  logic [31:0] q;
  dmw_link_if dmw_link_if_inst ();
  dmw_host dmw_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link(dmw_link_if_inst.host));
  dmw_device dmw_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(dmw_link_if_inst.dev),
    .analog_out_ch1_o(a1), .analog_out_ch2_o(a2), .phase_dir_out_ch1_o(d1),
    .phase_dir_out_ch2_o(d2), .fast_decay_n_ch1_o(f1), .fast_decay_n_ch2_o(f2));
  dmw_link_monitor dmw_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .data(dmw_link_if_inst.data), .chan_sel(dmw_link_if_inst.chan_sel),
    .kind_sel(dmw_link_if_inst.kind_sel), .cs_n(dmw_link_if_inst.cs_n),
    .wr_n(dmw_link_if_inst.wr_n), .dev_rst(dmw_link_if_inst.dev_rst),
    .analog_out_ch1_o(a1), .analog_out_ch2_o(a2), .phase_dir_out_ch1_o(d1),
    .phase_dir_out_ch2_o(d2), .fast_decay_n_ch1_o(f1), .fast_decay_n_ch2_o(f2));
  // 40 MHz clock
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  // hang guard, far above the expected run
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end
  // compare and count
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one classic wishbone cycle, held until ack is sampled
  task wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    do @(posedge clk_i);
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // poll status until the link strobe is done
  task wait_idle();
    int n;
    n = 0;
    do
    begin
      wb(4'h4, 1'b0, 32'h0, q);
      n++;
    end
    while (q[0] !== 1'b0 && n < 40);
    check("busy", {31'h0, q[0]}, 32'h0);
  endtask : wait_idle
  // one device write and the expected outputs
  task issue(input logic c, input logic k, input logic [7:0] d);
    logic fd;
    wb(4'h0, 1'b1, {22'h0, k, c, d}, q);
    wait_idle();
    check("other channel", c ? a1 : a2, mag[!c]);
    if (k)
    begin
      lvl[c] = d[6:4]; // level only, outputs untouched
      check("level quiet", c ? a2 : a1, mag[c]);
    end
    else
    begin
      fd = !((d[6:0] < mag[c]) && (d[6:4] < lvl[c]));
      mag[c] = d[6:0];
      check("direction", c ? d2 : d1, d[7]);
      check("magnitude", c ? a2 : a1, d[6:0]);
      check("decay", c ? f2 : f1, fd);
    end
  endtask : issue
  // verdict, the only exit
  task conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  // main sequence
  initial
  begin
    mag = '{7'h00, 7'h00};
    lvl = '{3'h0, 3'h0};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset outputs", {a1, a2, d1, d2, f1, f2}, 32'h0);
    // rising and falling magnitudes around the threshold, both channels
    for (int c = 0; c < 2; c++)
    begin
      issue(c[0], 1'b1, 8'h30);
      issue(c[0], 1'b0, 8'hd5);
      issue(c[0], 1'b0, 8'h20);
      issue(c[0], 1'b0, 8'h10);
      issue(c[0], 1'b0, 8'hb5);
      issue(c[0], 1'b0, 8'h30);
    end
    // a command while busy is dropped
    wb(4'h0, 1'b1, 32'h0000_007f, q);
    wb(4'h0, 1'b1, 32'h0000_0001, q);
    wait_idle();
    check("busy drop", a1, 7'h7f);
    wb(4'h0, 1'b0, 32'h0, q);
    check("command back", q[9:0], 10'h07f);
    mag[0] = 7'h7f;
    wb(4'h6, 1'b0, 32'h0, q);
    check("unmapped", q, 32'h0);
    // reset pin clears everything
    wb(4'h8, 1'b1, 32'h1, q);
    wb(4'h8, 1'b0, 32'h0, q);
    check("reset reg", q, 32'h1);
    wb(4'h8, 1'b1, 32'h0, q);
    check("pin reset", {a1, a2, d1, d2, f1, f2}, 32'h0);
    mag = '{7'h00, 7'h00};
    lvl = '{3'h0, 3'h0};
    issue(1'b1, 1'b0, 8'h85);
    conclude();
  end
endmodule : dmw_tb_top
